/* design/lpcc_defines.svh */
/*
  Constants for the low-power clock control block: reset values, source encodings, timing counts.
  Assumes a 200 MHz mclk_i and inclusion by bare name.
*/
`ifndef LPCC_DEFINES_SVH
`define LPCC_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS 5000
`define VREF_SETTLE_NS 1000
`define VREF_SETTLE_CYC ((`VREF_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define QUEUE_DRAIN_CYC 4

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define SRC_ONCHIP 2'h0
`define SRC_MAIN 2'h1
`define SRC_SUB 2'h2

`endif

/* design/lpcc_pkg.sv */
/*
  Types shared by the low-power clock control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lpcc_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT_DRAIN = 2'b01,
    ST_WAIT = 2'b10,
    ST_STOP = 2'b11
  } pmode_t;

  typedef struct packed {
    logic all_clock_stop_bit;
    logic periph_clock_stop_in_wait;
    logic vref_connect_bit;
    logic [1:0] clk_src;
  } clk_ctrl_t;

endpackage : lpcc_pkg

/* design/low_power_clock_control.sv */
/*
  Power-mode sequencer, clock-source select, peripheral clock gating, reference cut and
  self-clearing second write protect for a small microcontroller.
  Assumes the CPU core presents wait and bit-write strobes synchronous to mclk_i.
*/
`include "lpcc_defines.svh"

module low_power_clock_control
  import lpcc_pkg::*;
#(
  parameter int VREF_SETTLE = `VREF_SETTLE_CYC,
  parameter int QUEUE_DRAIN = `QUEUE_DRAIN_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // CPU requests
  input wire logic wait_req_i,
  input wire logic irq_pending_i,
  input wire logic bus_write_i,
  // Control bit writes
  input wire logic ctrl_we_i,
  input wire clk_ctrl_t ctrl_i,
  input wire logic protect_2_set_i,
  // Oscillator status
  input wire logic main_stable_i,
  input wire logic sub_stable_i,
  // Port state from the core
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] port_dir_i,
  // Outputs
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic subclock_peripheral_clock_en_o,
  output logic [1:0] clk_src_o,
  output logic vref_on_o,
  output logic vref_ready_o,
  output logic protect_enable_2_o,
  output logic stopped_o,
  output logic [7:0] port_out_o,
  output logic [7:0] port_dir_o
);

  // ----------------------------------------
  // Control bits and mode
  // ----------------------------------------
  pmode_t mode_q, mode_d;
  clk_ctrl_t ctrl_q, ctrl_d;
  logic [2:0] drain_q, drain_d;
  logic [7:0] vcnt_q, vcnt_d;
  logic protect_enable_2_q, protect_enable_2_d;
  logic [7:0] pout_q, pout_d, pdir_q, pdir_d;
  logic cpu_en_q, cpu_en_d, per_en_q, per_en_d, vrdy_q, vrdy_d;
  logic sub_en_q, sub_en_d, stop_q, stop_d;

  always_comb begin
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    drain_d = drain_q;
    protect_enable_2_d = protect_enable_2_q;
    if (ctrl_we_i && mode_q == ST_RUN) begin
      ctrl_d = ctrl_i;
    end
    // Second protect: a pending enable is consumed by the next write
    if (protect_enable_2_q && bus_write_i) begin
      protect_enable_2_d = 1'b0;
    end else if (protect_2_set_i) begin
      protect_enable_2_d = 1'b1;
    end
    unique case (mode_q)
      ST_RUN: begin
        drain_d = 3'h0;
        if (ctrl_we_i && ctrl_i.all_clock_stop_bit) begin
          mode_d = ST_STOP;
        end else if (wait_req_i) begin
          mode_d = ST_WAIT_DRAIN;
        end
      end
      ST_WAIT_DRAIN: begin
        // Queue keeps running a few cycles; an interrupt here aborts the wait
        drain_d = drain_q + 3'h1;
        if (irq_pending_i) begin
          mode_d = ST_RUN;
        end else if (32'(drain_q) + 1 >= QUEUE_DRAIN) begin
          mode_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (irq_pending_i) begin
          mode_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (irq_pending_i) begin
          mode_d = ST_RUN;
          ctrl_d.all_clock_stop_bit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_q <= ST_RUN;
      ctrl_q <= '{1'b0, 1'b0, 1'b0, `SRC_ONCHIP};
      drain_q <= 3'h0;
      protect_enable_2_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      drain_q <= drain_d;
      protect_enable_2_q <= protect_enable_2_d;
    end
  end

  // ----------------------------------------
  // Clock enables, reference timer, port hold
  // ----------------------------------------
  always_comb begin
    cpu_en_d = (mode_d == ST_RUN) || (mode_d == ST_WAIT_DRAIN);
    per_en_d = (mode_d == ST_RUN) || (mode_d == ST_WAIT_DRAIN)
      || (mode_d == ST_WAIT && !ctrl_d.periph_clock_stop_in_wait);
    // Slow sub-derived clock ignores the wait gating; only stop halts it
    sub_en_d = (mode_d != ST_STOP);
    stop_d = (mode_d == ST_STOP);
    vcnt_d = vcnt_q;
    vrdy_d = 1'b0;
    if (!ctrl_q.vref_connect_bit) begin
      vcnt_d = 8'h0;
    end else if (32'(vcnt_q) < VREF_SETTLE) begin
      vcnt_d = vcnt_q + 8'h1;
    end
    // Next-state bit, so ready falls in the same cycle as the cut
    if (ctrl_d.vref_connect_bit && 32'(vcnt_d) >= VREF_SETTLE) begin
      vrdy_d = 1'b1;
    end
    // Pins frozen while halted so peripherals see no glitch
    pout_d = pout_q;
    pdir_d = pdir_q;
    if (mode_q == ST_RUN || mode_q == ST_WAIT_DRAIN) begin
      pout_d = port_out_i;
      pdir_d = port_dir_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cpu_en_q <= 1'b1;
      per_en_q <= 1'b1;
      sub_en_q <= 1'b1;
      stop_q <= 1'b0;
      vcnt_q <= 8'h0;
      vrdy_q <= 1'b0;
      pout_q <= 8'h0;
      pdir_q <= 8'h0;
    end else begin
      cpu_en_q <= cpu_en_d;
      per_en_q <= per_en_d;
      sub_en_q <= sub_en_d;
      stop_q <= stop_d;
      vcnt_q <= vcnt_d;
      vrdy_q <= vrdy_d;
      pout_q <= pout_d;
      pdir_q <= pdir_d;
    end
  end

  assign cpu_clk_en_o = cpu_en_q;
  assign periph_clk_en_o = per_en_q;
  assign subclock_peripheral_clock_en_o = sub_en_q;
  assign clk_src_o = ctrl_q.clk_src;
  assign vref_on_o = ctrl_q.vref_connect_bit;
  assign vref_ready_o = vrdy_q;
  assign protect_enable_2_o = protect_enable_2_q;
  assign stopped_o = stop_q;
  assign port_out_o = pout_q;
  assign port_dir_o = pdir_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reset_src_a: assert property (@(posedge mclk_i) rst_i |=> clk_src_o == `SRC_ONCHIP)
    else $error("clock source not on-chip after reset");
  stop_entry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode_q == ST_RUN && ctrl_we_i && ctrl_i.all_clock_stop_bit)
    |=> stopped_o && !cpu_clk_en_o)
    else $error("stop not entered");
  stop_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    stopped_o |-> !cpu_clk_en_o && !periph_clk_en_o && !subclock_peripheral_clock_en_o)
    else $error("a clock still runs in stop");
  wait_drain_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode_q == ST_RUN && wait_req_i && !(ctrl_we_i && ctrl_i.all_clock_stop_bit))
    |=> cpu_clk_en_o)
    else $error("cpu clock cut before queue drained");
  port_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode_q == ST_WAIT || mode_q == ST_STOP) |=> $stable(port_out_o) && $stable(port_dir_o))
    else $error("port changed while halted");
  vref_cut_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !vref_on_o |-> !vref_ready_o)
    else $error("reference ready while cut");
  slow_clk_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_q == ST_WAIT |-> subclock_peripheral_clock_en_o)
    else $error("slow peripheral clock stopped in wait");
  wait_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_q == ST_WAIT |-> periph_clk_en_o == !ctrl_q.periph_clock_stop_in_wait)
    else $error("peripheral clock gating wrong in wait");
  protect_clr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (protect_enable_2_o && bus_write_i) |=> !protect_enable_2_o)
    else $error("second protect not cleared by write");
  wake_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((mode_q == ST_WAIT || mode_q == ST_STOP) && irq_pending_i) |=> cpu_clk_en_o && !stopped_o)
    else $error("interrupt did not restart cpu clock");

endmodule : low_power_clock_control

/* tb/testbench.sv */
/*
  Self-checking bench for the low-power clock control block: stop, wait, reset exit,
  reference settle and second write protect.
  Assumes the design package and header are compiled first.
*/
module testbench
  import lpcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int VS = 4;
  localparam int QD = 4;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wait_req_i = 1'b0;
  logic irq_pending_i = 1'b0;
  logic bus_write_i = 1'b0;
  logic ctrl_we_i = 1'b0;
  clk_ctrl_t ctrl_i = '0;
  logic protect_2_set_i = 1'b0;
  logic [7:0] port_out_i = 8'ha5;
  logic [7:0] port_dir_i = 8'h0f;
  logic cpu_clk_en_o, periph_clk_en_o, sub_en_o, vref_on_o, vref_ready_o, prot_o, stopped_o;
  logic [1:0] clk_src_o;
  logic [7:0] port_out_o, port_dir_o;
  int num_errors = 0;
  int n_checks = 0;

  low_power_clock_control #(.VREF_SETTLE(VS), .QUEUE_DRAIN(QD)) low_power_clock_control_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .wait_req_i(wait_req_i), .irq_pending_i(irq_pending_i),
    .bus_write_i(bus_write_i), .ctrl_we_i(ctrl_we_i), .ctrl_i(ctrl_i),
    .protect_2_set_i(protect_2_set_i), .main_stable_i(1'b1), .sub_stable_i(1'b1),
    .port_out_i(port_out_i), .port_dir_i(port_dir_i), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .subclock_peripheral_clock_en_o(sub_en_o),
    .clk_src_o(clk_src_o), .vref_on_o(vref_on_o), .vref_ready_o(vref_ready_o),
    .protect_enable_2_o(prot_o), .stopped_o(stopped_o), .port_out_o(port_out_o),
    .port_dir_o(port_dir_o));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task tick(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  task chk(logic ok, string m);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  task wr(clk_ctrl_t v);
    ctrl_i = v;
    ctrl_we_i = 1'b1;
    tick(1);
    ctrl_we_i = 1'b0;
  endtask : wr

  task wake();
    irq_pending_i = 1'b1;
    tick(1);
    irq_pending_i = 1'b0;
  endtask : wake

  task stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_stop();
    wr(clk_ctrl_t'{1'b1, 1'b0, 1'b0, 2'h1});
    chk(stopped_o === 1'b1 && cpu_clk_en_o === 1'b0 && sub_en_o === 1'b0, "stop entry");
    chk(periph_clk_en_o === 1'b0 && clk_src_o === 2'h1, "stop gating");
    port_out_i = 8'h5a;
    port_dir_i = 8'hf0;
    wr('0);
    tick(2);
    chk(stopped_o === 1'b1 && clk_src_o === 2'h1, "write in stop not ignored");
    chk(port_out_o === 8'ha5 && port_dir_o === 8'h0f, "ports not held in stop");
    wake();
    chk(stopped_o === 1'b0 && cpu_clk_en_o === 1'b1 && sub_en_o === 1'b1, "stop exit");
    tick(1);
    chk(port_out_o === 8'h5a && port_dir_o === 8'hf0, "ports frozen after wake");
    $display("stop test done");
  endtask : t_stop

  task t_rst_stop();
    wait_req_i = 1'b1;
    wr(clk_ctrl_t'{1'b1, 1'b0, 1'b0, 2'h1});
    wait_req_i = 1'b0;
    chk(stopped_o === 1'b1, "stop write did not win over wait");
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    chk(clk_src_o === 2'h0 && stopped_o === 1'b0 && cpu_clk_en_o === 1'b1, "reset exit");
    $display("reset exit test done");
  endtask : t_rst_stop

  task t_wait();
    for (int b = 0; b < 3; b++) begin
      wr(clk_ctrl_t'{1'b0, b == 1, 1'b0, (b == 2) ? 2'h2 : 2'h0});
      wait_req_i = 1'b1;
      tick(1);
      wait_req_i = 1'b0;
      tick(QD - 1);
      chk(cpu_clk_en_o === 1'b1, "cpu halted before drain");
      tick(1);
      chk(cpu_clk_en_o === 1'b0 && sub_en_o === 1'b1, "wait clocks");
      chk(periph_clk_en_o === (b != 1), "peripheral gating in wait");
      wake();
      chk(cpu_clk_en_o === 1'b1 && periph_clk_en_o === 1'b1, "irq exit from wait");
    end
    wait_req_i = 1'b1;
    tick(1);
    wait_req_i = 1'b0;
    wake();
    tick(QD + 2);
    chk(cpu_clk_en_o === 1'b1, "irq in drain did not abort wait");
    $display("wait test done");
  endtask : t_wait

  task t_vref();
    wr(clk_ctrl_t'{1'b0, 1'b0, 1'b1, 2'h0});
    chk(vref_on_o === 1'b1 && vref_ready_o === 1'b0, "reference connect");
    tick(VS - 1);
    chk(vref_ready_o === 1'b0, "reference ready too early");
    tick(1);
    chk(vref_ready_o === 1'b1, "reference settle");
    wr('0);
    chk(vref_on_o === 1'b0 && vref_ready_o === 1'b0, "reference cut");
    $display("reference test done");
  endtask : t_vref

  task t_prot();
    protect_2_set_i = 1'b1;
    bus_write_i = 1'b1;
    tick(1);
    protect_2_set_i = 1'b0;
    bus_write_i = 1'b0;
    chk(prot_o === 1'b1, "setting write consumed the enable");
    tick(2);
    chk(prot_o === 1'b1, "protect enable lost");
    bus_write_i = 1'b1;
    tick(1);
    bus_write_i = 1'b0;
    chk(prot_o === 1'b0, "protect not cleared by write");
    protect_2_set_i = 1'b1;
    tick(1);
    bus_write_i = 1'b1;
    tick(1);
    protect_2_set_i = 1'b0;
    bus_write_i = 1'b0;
    chk(prot_o === 1'b0, "write with set did not clear");
    $display("protect test done");
  endtask : t_prot

  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  initial begin
    tick(16);
    rst_i = 1'b0;
    chk(clk_src_o === 2'h0 && cpu_clk_en_o === 1'b1 && prot_o === 1'b0, "reset values");
    t_stop();
    t_rst_stop();
    t_wait();
    t_vref();
    t_prot();
    stop_test();
  end

  initial begin
    repeat (2000) @(posedge mclk_i);
    num_errors++;
    stop_test();
  end
endmodule : testbench
